// file: verilog/tsr_regmap.sv
// Summary of operation
// [RQ1] Fraction in top three bits, 0.125 steps
// [RQ2] Fraction valid only at rate 05h or below
// [RQ3] Two's complement; above 127 saturates, fraction zero
// [RQ4] 00h local, 01h banked remote integer
// [RQ5] 11h local, 10h banked remote fraction
// [RQ6] Status 02h resets 80h, 12h resets 00h
// [RQ7] Config read 03h, written 09h
// [RQ8] Rate read 04h, written 0Ah, reset 06h
// [RQ9] Local alert limits 05h/06h, 0Bh/0Ch
// [RQ10] Remote alert limits banked by config bit 3
// [RQ11] Second overtemp limits 16h banked, 17h local
// [RQ12] First overtemp limits 19h banked, 20h local
// [RQ13] Overtemp release below limit minus hysteresis
// [RQ14] Single conversion command starts conversion at once
// [RQ15] Integer registers signed, one degree per LSB
// [RQ16] Host reads integer and fraction between conversions
// [RQ17] Unmapped writes ignored, reads harmless
// [RQ18] Identity at FEh read-only fixed code
`timescale 1ns/1ps
`default_nettype none

module tsr_regmap #(
  parameter logic [6:0] SLAVE_ADDR = 7'h18,  // Serial slave address
  parameter logic [7:0] MAKER_ID   = 8'h5a   // Arbitrary identity value
) (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              smb_scl,
  input  wire logic              smb_sda_in,
  output logic                   smb_sda_out,
  output logic                   smb_sda_oe,
  input  wire logic              conv_done,
  input  wire logic [1:0]        conv_chan,
  input  wire logic signed [8:0] conv_int,
  input  wire logic [2:0]        conv_frac,
  input  wire logic [7:0]        status_first_in,
  input  wire logic [7:0]        status_second_in,
  output logic [7:0]             config_q,
  output logic [7:0]             conv_rate_q,
  output logic                   single_conversion_cmd,
  output logic                   overtemp_out_a,
  output logic                   overtemp_out_b
);

  // Reset synchroniser
  logic rst_s1_q;  // First reset stage
  logic rst_n;     // Released reset used by the design

  // Pin synchronisers and edge history
  logic scl_s1_q, scl_s2_q, scl_s3_q;  // Clock pin stages
  logic sda_s1_q, sda_s2_q, sda_s3_q;  // Data pin stages
  logic scl_rise, scl_fall;            // Clock pin edges
  logic bus_start, bus_stop;           // Start and stop conditions

  // Serial slave state
  tsr_pkg::tsr_state_t state_q;  // Slave state
  logic [3:0]          bit_cnt_q;  // Bits seen in current byte
  logic [7:0]          shift_q;    // Receive shift register
  logic [7:0]          tx_q;       // Transmit shift register
  logic                rw_q;       // Read request flag
  logic [7:0]          ptr_q;      // Command pointer

  // Stored registers
  logic [7:0] loc_int_q, loc_frac_q;              // Local result
  logic [7:0] rem_int_q [2], rem_frac_q [2];      // Remote results
  logic [7:0] stat1_q, stat2_q;                   // Status copies
  logic [7:0] loc_hi_q, loc_lo_q;                 // Local alert limits
  logic [7:0] rem_hi_q [2], rem_lo_q [2];         // Remote alert limits
  logic [7:0] loc_ota_q, loc_otb_q;               // Local overtemp limits
  logic [7:0] rem_ota_q [2], rem_otb_q [2];       // Remote overtemp limits
  logic [7:0] overtemp_hysteresis_q;                             // Overtemp hysteresis
  logic [2:0] ota_flag_q, otb_flag_q;             // Per channel overtemp

  // Decoded strobes
  logic       bank;       // Remote bank select
  logic       wr_en;      // Register write strobe
  logic [7:0] rd_data;    // Read mux output
  logic [7:0] sat_int;    // Saturated integer result
  logic [7:0] sat_frac;   // Fraction byte after rules

  // Reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Two-stage pin synchronisers plus one history stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= smb_scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= smb_sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // Edge and condition detection on synchronised pins
  assign scl_rise  = scl_s2_q & ~scl_s3_q;
  assign scl_fall  = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  assign bus_stop  = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

  assign bank  = config_q[tsr_pkg::CFG_REMOTE_SEL_BIT];
  assign wr_en = (state_q == tsr_pkg::ST_WDATA) && scl_fall &&
                 (bit_cnt_q == tsr_pkg::BITS_PER_BYTE);

  // Read mux; unmapped codes return a constant and touch nothing
  always_comb begin
    if (ptr_q == tsr_pkg::CMD_LOCAL_TEMP_INT) begin
      rd_data = loc_int_q;  // [RQ4]
    end else if (ptr_q == tsr_pkg::CMD_REMOTE_TEMP_INT) begin
      rd_data = rem_int_q[bank];  // [RQ4]
    end else if (ptr_q == tsr_pkg::CMD_STATUS_FIRST) begin
      rd_data = stat1_q;  // [RQ6]
    end else if (ptr_q == tsr_pkg::CMD_CONFIG_READBACK) begin
      rd_data = config_q;  // [RQ7]
    end else if (ptr_q == tsr_pkg::CMD_CONV_RATE_READBACK) begin
      rd_data = conv_rate_q;  // [RQ8]
    end else if (ptr_q == tsr_pkg::CMD_LOCAL_HIGH_RD) begin
      rd_data = loc_hi_q;  // [RQ9]
    end else if (ptr_q == tsr_pkg::CMD_LOCAL_LOW_RD) begin
      rd_data = loc_lo_q;  // [RQ9]
    end else if (ptr_q == tsr_pkg::CMD_REMOTE_HIGH_RD) begin
      rd_data = rem_hi_q[bank];  // [RQ10]
    end else if (ptr_q == tsr_pkg::CMD_REMOTE_LOW_RD) begin
      rd_data = rem_lo_q[bank];  // [RQ10]
    end else if (ptr_q == tsr_pkg::CMD_REMOTE_TEMP_FRAC) begin
      rd_data = rem_frac_q[bank];  // [RQ5]
    end else if (ptr_q == tsr_pkg::CMD_LOCAL_TEMP_FRAC) begin
      rd_data = loc_frac_q;  // [RQ5]
    end else if (ptr_q == tsr_pkg::CMD_STATUS_SECOND) begin
      rd_data = stat2_q;  // [RQ6]
    end else if (ptr_q == tsr_pkg::CMD_REMOTE_OT_B_LIMIT) begin
      rd_data = rem_otb_q[bank];  // [RQ11]
    end else if (ptr_q == tsr_pkg::CMD_LOCAL_OT_B_LIMIT) begin
      rd_data = loc_otb_q;  // [RQ11]
    end else if (ptr_q == tsr_pkg::CMD_REMOTE_OT_A_LIMIT) begin
      rd_data = rem_ota_q[bank];  // [RQ12]
    end else if (ptr_q == tsr_pkg::CMD_LOCAL_OT_A_LIMIT) begin
      rd_data = loc_ota_q;  // [RQ12]
    end else if (ptr_q == tsr_pkg::CMD_OT_HYSTERESIS) begin
      rd_data = overtemp_hysteresis_q;  // [RQ13]
    end else if (ptr_q == tsr_pkg::CMD_MAKER_IDENTITY) begin
      rd_data = MAKER_ID;  // [RQ18]
    end else begin
      rd_data = tsr_pkg::RST_UNMAPPED_RD;  // [RQ17]
    end
  end

  // Serial slave: address, command, write data and read data phases
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= tsr_pkg::ST_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 8'h00;
      tx_q       <= 8'h00;
      rw_q       <= 1'b0;
      smb_sda_oe <= 1'b0;
    end else if (bus_start) begin
      // Start or repeated start always restarts address phase
      state_q    <= tsr_pkg::ST_ADDR;
      bit_cnt_q  <= 4'h0;
      smb_sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state_q    <= tsr_pkg::ST_IDLE;
      smb_sda_oe <= 1'b0;
    end else begin
      case (state_q)
        tsr_pkg::ST_ADDR, tsr_pkg::ST_CMD, tsr_pkg::ST_WDATA: begin
          // Sample on clock rise, answer after eighth bit on clock fall
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s2_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == tsr_pkg::BITS_PER_BYTE) begin
            bit_cnt_q <= 4'h0;
            if (state_q == tsr_pkg::ST_ADDR) begin
              if (shift_q[7:1] == SLAVE_ADDR) begin
                rw_q       <= shift_q[0];
                smb_sda_oe <= 1'b1;
                state_q    <= tsr_pkg::ST_ADDR_ACK;
              end else begin
                state_q <= tsr_pkg::ST_IDLE;  // Not for us
              end
            end else if (state_q == tsr_pkg::ST_CMD) begin
              smb_sda_oe <= 1'b1;
              state_q    <= tsr_pkg::ST_CMD_ACK;
            end else begin
              smb_sda_oe <= 1'b1;
              state_q    <= tsr_pkg::ST_WDATA_ACK;
            end
          end
        end
        tsr_pkg::ST_ADDR_ACK: begin
          // End of acknowledge; a read drives its first bit here
          if (scl_fall) begin
            if (rw_q) begin
              tx_q       <= {rd_data[6:0], 1'b0};
              smb_sda_oe <= ~rd_data[7];
              state_q    <= tsr_pkg::ST_RDATA;
            end else begin
              smb_sda_oe <= 1'b0;
              state_q    <= tsr_pkg::ST_CMD;
            end
          end
        end
        tsr_pkg::ST_CMD_ACK: begin
          if (scl_fall) begin
            smb_sda_oe <= 1'b0;
            state_q    <= tsr_pkg::ST_WDATA;
          end
        end
        tsr_pkg::ST_WDATA_ACK: begin
          // Extra bytes after one data byte are not acknowledged
          if (scl_fall) begin
            smb_sda_oe <= 1'b0;
            state_q    <= tsr_pkg::ST_IDLE;
          end
        end
        tsr_pkg::ST_RDATA: begin
          // Shift out most significant bit first
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == tsr_pkg::BITS_PER_BYTE) begin
              bit_cnt_q  <= 4'h0;
              smb_sda_oe <= 1'b0;
              state_q    <= tsr_pkg::ST_MASTER_ACK;
            end else begin
              smb_sda_oe <= ~tx_q[7];
              tx_q       <= {tx_q[6:0], 1'b0};
            end
          end
        end
        tsr_pkg::ST_MASTER_ACK: begin
          // Master acknowledge repeats the same register, otherwise done
          if (scl_rise) begin
            state_q <= sda_s2_q ? tsr_pkg::ST_IDLE : tsr_pkg::ST_ADDR_ACK;
          end
        end
        default: begin
          smb_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain data pin only ever pulls low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      smb_sda_out <= 1'b0;
    end else begin
      smb_sda_out <= 1'b0;
    end
  end

  // Command pointer, updated by the command byte, kept for receive byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= tsr_pkg::CMD_LOCAL_TEMP_INT;
    end else if (state_q == tsr_pkg::ST_CMD && scl_fall &&
                 bit_cnt_q == tsr_pkg::BITS_PER_BYTE) begin
      ptr_q <= shift_q;
    end
  end

  // Single conversion pulse as soon as its command byte arrives
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      single_conversion_cmd <= 1'b0;
    end else begin
      single_conversion_cmd <= (state_q == tsr_pkg::ST_CMD) && scl_fall &&
                               (bit_cnt_q == tsr_pkg::BITS_PER_BYTE) &&
                               (shift_q == tsr_pkg::CMD_SINGLE_CONVERSION);  // [RQ14]
    end
  end

  // Host-writable registers; unmapped and read-only codes fall through
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_q     <= tsr_pkg::RST_CONFIG;
      conv_rate_q  <= tsr_pkg::RST_CONV_RATE;
      loc_hi_q     <= tsr_pkg::RST_ALERT_HIGH;
      loc_lo_q     <= tsr_pkg::RST_ALERT_LOW;
      rem_hi_q[0]  <= tsr_pkg::RST_ALERT_HIGH;
      rem_hi_q[1]  <= tsr_pkg::RST_ALERT_HIGH;
      rem_lo_q[0]  <= tsr_pkg::RST_ALERT_LOW;
      rem_lo_q[1]  <= tsr_pkg::RST_ALERT_LOW;
      loc_otb_q    <= tsr_pkg::RST_LOC_OT_B;
      rem_otb_q[0] <= tsr_pkg::RST_REM_OT_B;
      rem_otb_q[1] <= tsr_pkg::RST_REM_OT_B;
      loc_ota_q    <= tsr_pkg::RST_LOC_OT_A;
      rem_ota_q[0] <= tsr_pkg::RST_REM_OT_A;
      rem_ota_q[1] <= tsr_pkg::RST_REM_OT_A;
      overtemp_hysteresis_q       <= tsr_pkg::RST_HYSTERESIS;
    end else if (wr_en) begin
      if (ptr_q == tsr_pkg::CMD_CONFIG_WRITE) begin
        config_q <= shift_q;  // [RQ7]
      end else if (ptr_q == tsr_pkg::CMD_CONV_RATE_WRITE) begin
        conv_rate_q <= shift_q;  // [RQ8]
      end else if (ptr_q == tsr_pkg::CMD_LOCAL_HIGH_WR) begin
        loc_hi_q <= shift_q;  // [RQ9]
      end else if (ptr_q == tsr_pkg::CMD_LOCAL_LOW_WR) begin
        loc_lo_q <= shift_q;  // [RQ9]
      end else if (ptr_q == tsr_pkg::CMD_REMOTE_HIGH_WR) begin
        rem_hi_q[bank] <= shift_q;  // [RQ10]
      end else if (ptr_q == tsr_pkg::CMD_REMOTE_LOW_WR) begin
        rem_lo_q[bank] <= shift_q;  // [RQ10]
      end else if (ptr_q == tsr_pkg::CMD_REMOTE_OT_B_LIMIT) begin
        rem_otb_q[bank] <= shift_q;  // [RQ11]
      end else if (ptr_q == tsr_pkg::CMD_LOCAL_OT_B_LIMIT) begin
        loc_otb_q <= shift_q;  // [RQ11]
      end else if (ptr_q == tsr_pkg::CMD_REMOTE_OT_A_LIMIT) begin
        rem_ota_q[bank] <= shift_q;  // [RQ12]
      end else if (ptr_q == tsr_pkg::CMD_LOCAL_OT_A_LIMIT) begin
        loc_ota_q <= shift_q;  // [RQ12]
      end else if (ptr_q == tsr_pkg::CMD_OT_HYSTERESIS) begin
        overtemp_hysteresis_q <= shift_q;  // [RQ13]
      end
    end
  end

  // Saturate the signed result and apply the fraction rules
  always_comb begin
    if ($signed(conv_int) > $signed(tsr_pkg::SAT_HIGH)) begin
      sat_int  = tsr_pkg::SAT_HIGH[7:0];  // [RQ3]
      sat_frac = 8'h00;  // [RQ3]
    end else if ($signed(conv_int) < $signed(tsr_pkg::SAT_LOW)) begin
      sat_int  = tsr_pkg::SAT_LOW[7:0];
      sat_frac = 8'h00;
    end else begin
      sat_int  = conv_int[7:0];  // [RQ15]
      sat_frac = {conv_frac, 5'h00};  // [RQ1]
    end
    if (conv_rate_q > tsr_pkg::FRAC_MAX_RATE) begin
      sat_frac = 8'h00;  // [RQ2]
    end
  end

  // Result and status capture; integer and fraction update together
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loc_int_q     <= tsr_pkg::RST_TEMP;
      loc_frac_q    <= tsr_pkg::RST_TEMP;
      rem_int_q[0]  <= tsr_pkg::RST_TEMP;
      rem_int_q[1]  <= tsr_pkg::RST_TEMP;
      rem_frac_q[0] <= tsr_pkg::RST_TEMP;
      rem_frac_q[1] <= tsr_pkg::RST_TEMP;
      stat1_q       <= tsr_pkg::RST_STATUS_1;
      stat2_q       <= tsr_pkg::RST_STATUS_2;
    end else if (conv_done) begin
      stat1_q <= status_first_in;  // [RQ6]
      stat2_q <= status_second_in;  // [RQ6]
      if (conv_chan == tsr_pkg::CHAN_LOCAL) begin
        loc_int_q  <= sat_int;  // [RQ4]
        loc_frac_q <= sat_frac;  // [RQ5]
      end else if (conv_chan == tsr_pkg::CHAN_REMOTE1) begin
        rem_int_q[0]  <= sat_int;
        rem_frac_q[0] <= sat_frac;
      end else if (conv_chan == tsr_pkg::CHAN_REMOTE2) begin
        rem_int_q[1]  <= sat_int;
        rem_frac_q[1] <= sat_frac;
      end
    end
  end

  // Per channel overtemperature comparators with hysteresis
  for (genvar ch = 0; ch < 3; ch++) begin : g_ot
    logic signed [8:0] lim_a, lim_b, rel_a, rel_b, temp;  // Comparison terms
    assign lim_a = (ch == 0) ? {loc_ota_q[7], loc_ota_q}
                             : {rem_ota_q[(ch+1)%2][7], rem_ota_q[(ch+1)%2]};
    assign lim_b = (ch == 0) ? {loc_otb_q[7], loc_otb_q}
                             : {rem_otb_q[(ch+1)%2][7], rem_otb_q[(ch+1)%2]};
    assign rel_a = lim_a - $signed({overtemp_hysteresis_q[7], overtemp_hysteresis_q});
    assign rel_b = lim_b - $signed({overtemp_hysteresis_q[7], overtemp_hysteresis_q});
    assign temp  = {sat_int[7], sat_int};

    // Set at or above limit, clear only below limit minus hysteresis
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        ota_flag_q[ch] <= 1'b0;
        otb_flag_q[ch] <= 1'b0;
      end else if (conv_done && conv_chan == 2'(ch)) begin
        if (temp >= lim_a) begin
          ota_flag_q[ch] <= 1'b1;
        end else if (temp < rel_a) begin
          ota_flag_q[ch] <= 1'b0;  // [RQ13]
        end
        if (temp >= lim_b) begin
          otb_flag_q[ch] <= 1'b1;
        end else if (temp < rel_b) begin
          otb_flag_q[ch] <= 1'b0;  // [RQ13]
        end
      end
    end
  end

  // Overtemperature outputs registered from channel flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_out_a <= 1'b0;
      overtemp_out_b <= 1'b0;
    end else begin
      overtemp_out_a <= |ota_flag_q;  // [RQ13]
      overtemp_out_b <= |otb_flag_q;  // [RQ13]
    end
  end

endmodule : tsr_regmap

`default_nettype wire

// file: verilog/tsr_pkg.sv
// Shared constants of the temperature sensor register map
package tsr_pkg;

  // Command codes (register pointers)
  localparam logic [7:0] CMD_LOCAL_TEMP_INT     = 8'h00;
  localparam logic [7:0] CMD_REMOTE_TEMP_INT    = 8'h01;
  localparam logic [7:0] CMD_STATUS_FIRST       = 8'h02;
  localparam logic [7:0] CMD_CONFIG_READBACK    = 8'h03;
  localparam logic [7:0] CMD_CONV_RATE_READBACK = 8'h04;
  localparam logic [7:0] CMD_LOCAL_HIGH_RD      = 8'h05;
  localparam logic [7:0] CMD_LOCAL_LOW_RD       = 8'h06;
  localparam logic [7:0] CMD_REMOTE_HIGH_RD     = 8'h07;
  localparam logic [7:0] CMD_REMOTE_LOW_RD      = 8'h08;
  localparam logic [7:0] CMD_CONFIG_WRITE       = 8'h09;
  localparam logic [7:0] CMD_CONV_RATE_WRITE    = 8'h0a;
  localparam logic [7:0] CMD_LOCAL_HIGH_WR      = 8'h0b;
  localparam logic [7:0] CMD_LOCAL_LOW_WR       = 8'h0c;
  localparam logic [7:0] CMD_REMOTE_HIGH_WR     = 8'h0d;
  localparam logic [7:0] CMD_REMOTE_LOW_WR      = 8'h0e;
  localparam logic [7:0] CMD_SINGLE_CONVERSION  = 8'h0f;
  localparam logic [7:0] CMD_REMOTE_TEMP_FRAC   = 8'h10;
  localparam logic [7:0] CMD_LOCAL_TEMP_FRAC    = 8'h11;
  localparam logic [7:0] CMD_STATUS_SECOND      = 8'h12;
  localparam logic [7:0] CMD_REMOTE_OT_B_LIMIT  = 8'h16;
  localparam logic [7:0] CMD_LOCAL_OT_B_LIMIT   = 8'h17;
  localparam logic [7:0] CMD_REMOTE_OT_A_LIMIT  = 8'h19;
  localparam logic [7:0] CMD_LOCAL_OT_A_LIMIT   = 8'h20;
  localparam logic [7:0] CMD_OT_HYSTERESIS      = 8'h21;
  localparam logic [7:0] CMD_MAKER_IDENTITY     = 8'hfe;

  // Reset values
  localparam logic [7:0] RST_TEMP        = 8'h00;
  localparam logic [7:0] RST_STATUS_1    = 8'h80;
  localparam logic [7:0] RST_STATUS_2    = 8'h00;
  localparam logic [7:0] RST_CONFIG      = 8'h00;
  localparam logic [7:0] RST_CONV_RATE   = 8'h06;
  localparam logic [7:0] RST_ALERT_HIGH  = 8'h46;
  localparam logic [7:0] RST_ALERT_LOW   = 8'hc9;
  localparam logic [7:0] RST_REM_OT_B    = 8'h78;
  localparam logic [7:0] RST_LOC_OT_B    = 8'h5a;
  localparam logic [7:0] RST_REM_OT_A    = 8'h5a;
  localparam logic [7:0] RST_LOC_OT_A    = 8'h46;
  localparam logic [7:0] RST_HYSTERESIS  = 8'h0a;
  localparam logic [7:0] RST_UNMAPPED_RD = 8'h00;

  // Field positions and limits
  localparam int         CFG_REMOTE_SEL_BIT = 3;
  localparam logic [7:0] FRAC_MAX_RATE      = 8'h05;
  localparam int         FRAC_LSB_POS       = 5;
  localparam logic [8:0] SAT_HIGH           = 9'h07f;
  localparam logic [8:0] SAT_LOW            = 9'h180;

  // Conversion channel codes
  localparam logic [1:0] CHAN_LOCAL   = 2'h0;
  localparam logic [1:0] CHAN_REMOTE1 = 2'h1;
  localparam logic [1:0] CHAN_REMOTE2 = 2'h2;

  // Serial bit counting
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Serial slave states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_MASTER_ACK
  } tsr_state_t;

endpackage : tsr_pkg

// file: dv/tsr_regmap_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the register map
module tsr_regmap_sva (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       smb_scl,
  input wire logic       smb_sda_oe,
  input wire logic       conv_done,
  input wire logic [7:0] config_q,
  input wire logic [7:0] conv_rate_q,
  input wire logic       single_conversion_cmd,
  input wire logic       overtemp_out_a,
  input wire logic       overtemp_out_b
);
  // One clock domain, raw reset pin
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  AST_CFG_RESET: assert property ($rose(reset_n) |-> config_q == 8'h00)
    else $error("config not clear after reset");
  AST_RATE_RESET: assert property ($rose(reset_n) |-> conv_rate_q == 8'h06)
    else $error("rate not 06 after reset");
  AST_CFG_IDLE: assert property (smb_scl [*8] |=> $stable(config_q))
    else $error("config moved with the bus idle");
  AST_RATE_APART: assert property ($changed(conv_rate_q) |-> $stable(config_q))
    else $error("rate and config changed together");
  AST_SHOT_PULSE: assert property (single_conversion_cmd |=> !single_conversion_cmd)
    else $error("single conversion pulse too long");
  AST_SHOT_NO_ACK: assert property (single_conversion_cmd |-> smb_sda_oe)
    else $error("single conversion pulse without ack");
  AST_OT_A_CAUSE: assert property ($changed(overtemp_out_a) |-> $past(conv_done, 2))
    else $error("overtemp a moved without a result");
  AST_OT_B_CAUSE: assert property ($changed(overtemp_out_b) |-> $past(conv_done, 2))
    else $error("overtemp b moved without a result");
  // Main scenarios reached
  cover property (single_conversion_cmd);
  cover property ($rose(overtemp_out_a));
  cover property ($fell(overtemp_out_a));
endmodule : tsr_regmap_sva

bind tsr_regmap tsr_regmap_sva tsr_regmap_sva_i (.sys_clk, .reset_n, .smb_scl, .smb_sda_oe,
  .conv_done, .config_q, .conv_rate_q, .single_conversion_cmd, .overtemp_out_a,
  .overtemp_out_b);
`default_nettype wire

// file: dv/tsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host master: SCL period 8 clocks, wired-AND SDA
module tsr_host_model (
  input  wire logic sys_clk,
  input  wire logic smb_sda_out,
  input  wire logic smb_sda_oe,
  output var logic  smb_scl,
  output logic      smb_sda_in
);
  logic sda_m; // Level the host leaves on SDA
  // Either side may pull low, else pull-up
  assign smb_sda_in = sda_m & (smb_sda_oe ? smb_sda_out : 1'b1);
  // Bus idle: both lines high
  initial begin
    smb_scl = 1'b1;
    sda_m   = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // Data set in low phase, sampled late in high
  task automatic put_bit(input logic b, output logic r);
    tick(1);
    sda_m <= b;
    tick(4);
    smb_scl <= 1'b1;
    tick(3);
    r = smb_sda_in;
    smb_scl <= 1'b0;
  endtask : put_bit
  // Start or repeated start
  task automatic start;
    tick(1);
    sda_m <= 1'b1;
    tick(4);
    smb_scl <= 1'b1;
    tick(4);
    sda_m <= 1'b0;
    tick(4);
    smb_scl <= 1'b0;
  endtask : start
  task automatic stop;
    tick(1);
    sda_m <= 1'b0;
    tick(4);
    smb_scl <= 1'b1;
    tick(4);
    sda_m <= 1'b1;
    tick(4);
  endtask : stop
  // Byte MSB first, ninth bit released (ack read or nack sent)
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) put_bit(d[i], r[i]);
    put_bit(1'b1, a);
  endtask : xfer
endmodule : tsr_host_model
`default_nettype wire

// file: dv/tsr_regmap_test.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench over the serial link
module tsr_regmap_test;
  localparam logic [6:0] ADDR = 7'h18; // Slave address
  localparam logic [7:0] ID   = 8'h3c; // Arbitrary identity value
  localparam logic [7:0] RC [17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h10, 8'h11, 8'h12, 8'h16, 8'h17, 8'h19, 8'h20, 8'h21};
  localparam logic [7:0] RV [17] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h06, 8'h46, 8'hc9, 8'h46,
    8'hc9, 8'h00, 8'h00, 8'h00, 8'h78, 8'h5a, 8'h5a, 8'h46, 8'h0a};
  localparam logic [7:0] BW [4] = '{8'h0d, 8'h0e, 8'h16, 8'h19};
  localparam logic [7:0] BR [4] = '{8'h07, 8'h08, 8'h16, 8'h19};
  localparam logic [7:0] BV [4] = '{8'h55, 8'h11, 8'h66, 8'h77};
  localparam logic [7:0] B0 [4] = '{8'h46, 8'hc9, 8'h78, 8'h5a};
  localparam logic [7:0] LW [5] = '{8'h0b, 8'h0c, 8'h17, 8'h20, 8'h21};
  localparam logic [7:0] LR [5] = '{8'h05, 8'h06, 8'h17, 8'h20, 8'h21};
  localparam logic [7:0] LV [5] = '{8'h50, 8'hf0, 8'h64, 8'h40, 8'h05};
  logic              sys_clk, reset_n, smb_scl, smb_sda_in, smb_sda_out, smb_sda_oe;
  logic              conv_done, single_conversion_cmd, overtemp_out_a, overtemp_out_b, shot;
  logic [1:0]        conv_chan;
  logic signed [8:0] conv_int;
  logic [2:0]        conv_frac;
  logic [7:0]        status_first_in, status_second_in, config_q, conv_rate_q;
  int                mismatches, compares, cycles;
  tsr_regmap #(.SLAVE_ADDR(ADDR), .MAKER_ID(ID)) tsr_regmap_i (.sys_clk, .reset_n, .smb_scl,
    .smb_sda_in, .smb_sda_out, .smb_sda_oe, .conv_done, .conv_chan, .conv_int, .conv_frac,
    .status_first_in, .status_second_in, .config_q, .conv_rate_q, .single_conversion_cmd,
    .overtemp_out_a, .overtemp_out_b);
  tsr_host_model tsr_host_model_i (.sys_clk, .smb_sda_out, .smb_sda_oe, .smb_scl, .smb_sda_in);
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Write Byte, or Send Byte when dat is clear
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input bit dat);
    logic [7:0] r;
    logic       a;
    tsr_host_model_i.start();
    tsr_host_model_i.xfer({ADDR, 1'b0}, r, a);
    tsr_host_model_i.xfer(c, r, a);
    if (dat) tsr_host_model_i.xfer(d, r, a);
    tsr_host_model_i.stop();
  endtask : wr
  // Read Byte with nack, then compare
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] r;
    logic       a;
    tsr_host_model_i.start();
    tsr_host_model_i.xfer({ADDR, 1'b0}, r, a);
    tsr_host_model_i.xfer(c, r, a);
    tsr_host_model_i.start();
    tsr_host_model_i.xfer({ADDR, 1'b1}, r, a);
    tsr_host_model_i.xfer(8'hff, r, a);
    tsr_host_model_i.stop();
    chk(r, e);
  endtask : rd
  // One conversion result pulse
  task automatic conv(input logic [1:0] ch, input logic signed [8:0] t, input logic [2:0] f);
    conv_done <= 1'b1;
    conv_chan <= ch;
    conv_int  <= t;
    conv_frac <= f;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : conv
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Hang ceiling; single conversion catcher
  always @(posedge sys_clk) begin
    cycles++;
    if (single_conversion_cmd === 1'b1) shot <= 1'b1;
    if (cycles == 40000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    {reset_n, conv_done, conv_chan, conv_int, conv_frac, shot} <= '0;
    status_first_in  <= 8'h11;
    status_second_in <= 8'h22;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 17; i++) rd(RC[i], RV[i]);
    wr(8'hfe, 8'h00, 1);
    rd(8'hfe, ID);
    wr(8'h09, 8'h08, 1);
    rd(8'h03, 8'h08);
    wr(8'h0a, 8'h05, 1);
    rd(8'h04, 8'h05);
    conv(2'h2, 9'sd25, 3'h2);
    rd(8'h01, 8'h19);
    rd(8'h10, 8'h40);
    rd(8'h02, 8'h11);
    rd(8'h12, 8'h22);
    conv(2'h0, 9'sd200, 3'h5);
    rd(8'h00, 8'h7f);
    rd(8'h11, 8'h00);
    conv(2'h0, -9'sd1, 3'h2);
    rd(8'h00, 8'hff);
    rd(8'h11, 8'h40);
    wr(8'h0a, 8'h06, 1);
    conv(2'h0, 9'sd10, 3'h7);
    rd(8'h11, 8'h00);
    for (int i = 0; i < 4; i++) wr(BW[i], BV[i], 1);
    wr(8'h09, 8'h00, 1);
    for (int i = 0; i < 4; i++) rd(BR[i], B0[i]);
    rd(8'h01, 8'h00);
    wr(8'h09, 8'h08, 1);
    for (int i = 0; i < 4; i++) rd(BR[i], BV[i]);
    for (int i = 0; i < 5; i++) wr(LW[i], LV[i], 1);
    for (int i = 0; i < 5; i++) rd(LR[i], LV[i]);
    conv(2'h0, 9'sd64, 3'h0);
    chk({6'h00, overtemp_out_b, overtemp_out_a}, 8'h01);
    conv(2'h0, 9'sd59, 3'h0);
    chk({7'h00, overtemp_out_a}, 8'h01);
    conv(2'h0, 9'sd58, 3'h0);
    chk({7'h00, overtemp_out_a}, 8'h00);
    conv(2'h0, 9'sd100, 3'h0);
    chk({7'h00, overtemp_out_b}, 8'h01);
    wr(8'h0f, 8'h00, 0);
    chk({7'h00, shot}, 8'h01);
    wr(8'h13, 8'h5a, 1);
    rd(8'h13, 8'h00);
    rd(8'h03, 8'h08);
    chk(conv_rate_q, 8'h06);
    complete_run();
  end
endmodule : tsr_regmap_test
`default_nettype wire
